//--- core/iopc_port.sv
// I/O port with open-drain, analog config, change notification and interrupt 2 select
`default_nettype none

module iopc_port
   import iopc_pkg::*;
#(
   parameter int CN_COUNT = 21
) (
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire logic [iopc_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [15:0]               regWdata,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output logic     [15:0]               regRdata,
   input  wire logic [iopc_pkg::PORT_W-1:0] pinIn,
   output logic     [iopc_pkg::PORT_W-1:0] pinOut,
   output logic     [iopc_pkg::PORT_W-1:0] pinOe,
   output logic     [iopc_pkg::PORT_W-1:0] adcPinSample,
   output logic     [iopc_pkg::PORT_W-1:0] adcMuxGround,
   input  wire logic [CN_COUNT-1:0]        cnPins,
   output logic     [CN_COUNT-1:0]        cnPullupOn,
   input  wire logic [iopc_pkg::RP_COUNT-1:0] rpPins,
   output logic                           extInt2,
   output logic                           cnWake,
   output logic                           irq
);
   import iopc_pkg::*;

   logic [15:0] dir_reg;
   logic [15:0] latch_reg;
   logic [15:0] odc_reg;
   logic [15:0] ancfg_reg;
   logic [31:0] cnEn_reg;
   logic [31:0] cnPu_reg;
   logic [4:0]  int2Sel_reg;
   logic [IRQ_W-1:0] irqStat_reg;
   logic [IRQ_W-1:0] irqMask_reg;
   logic [IRQ_W-1:0] irqStat_next;
   logic [15:0] pinSyncA_reg;
   logic [15:0] pinSync_reg;
   logic [RP_COUNT-1:0] rpSyncA_reg;
   logic [RP_COUNT-1:0] rpSync_reg;
   logic        int2_reg;
   logic        int2Prev_reg;
   logic [15:0] portView;
   logic        changeEvent;
   logic        wakeRaw;
   logic        wr;
   logic        int2Rise;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign wr = regWrite;

   // Register writes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dir_reg     <= DIR_RST;
         latch_reg   <= ZERO_RST;
         odc_reg     <= ZERO_RST;
         ancfg_reg   <= ZERO_RST;
         cnEn_reg    <= '0;
         cnPu_reg    <= '0;
         int2Sel_reg <= INT2SEL_RST;
         irqMask_reg <= '0;
      end else if (wr) begin
         if (hit(regAddr, OFF_DIR))     dir_reg     <= regWdata;
         if (hit(regAddr, OFF_PORT))    latch_reg   <= regWdata;
         if (hit(regAddr, OFF_LATCH))   latch_reg   <= regWdata;
         if (hit(regAddr, OFF_ODC))     odc_reg     <= regWdata;
         if (hit(regAddr, OFF_ANCFG))   ancfg_reg   <= regWdata;
         if (hit(regAddr, OFF_CNEN_LO)) cnEn_reg[15:0]  <= regWdata;
         if (hit(regAddr, OFF_CNEN_HI)) cnEn_reg[31:16] <= {1'b0, regWdata[14:0]};
         if (hit(regAddr, OFF_CNPU_LO)) cnPu_reg[15:0]  <= regWdata;
         if (hit(regAddr, OFF_CNPU_HI)) cnPu_reg[31:16] <= {1'b0, regWdata[14:0]};
         if (hit(regAddr, OFF_INT2SEL)) int2Sel_reg <= regWdata[4:0];
         if (hit(regAddr, OFF_IRQMASK)) irqMask_reg <= regWdata[IRQ_W-1:0];
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinSyncA_reg <= '0;
         pinSync_reg  <= '0;
         rpSyncA_reg  <= '0;
         rpSync_reg   <= '0;
      end else begin
         pinSyncA_reg <= pinIn;
         pinSync_reg  <= pinSyncA_reg;
         rpSyncA_reg  <= rpPins;
         rpSync_reg   <= rpSyncA_reg;
      end
   end

   // Analog-configured pins read as zero
   assign portView = pinSync_reg & ancfg_reg;

   // Pin drivers: open-drain only ever drives low
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinOut <= '0;
         pinOe  <= '0;
      end else begin
         for (int i = 0; i < PORT_W; i++) begin
            if (odc_reg[i]) begin
               pinOut[i] <= 1'b0;
               pinOe[i]  <= !dir_reg[i] && !latch_reg[i];
            end else begin
               pinOut[i] <= latch_reg[i];
               pinOe[i]  <= !dir_reg[i];
            end
         end
      end
   end

   // Converter front end: analog pins sampled, digital pins grounded.
   // An output-driven analog pin hands over its latch level when push-pull, its synchronised pin level when open-drain.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         adcPinSample <= '0;
         adcMuxGround <= '0;
      end else begin
         for (int i = 0; i < PORT_W; i++) begin
            adcMuxGround[i] <= ancfg_reg[i];
            if (ancfg_reg[i]) begin
               adcPinSample[i] <= 1'b0;
            end else if (!dir_reg[i]) begin
               adcPinSample[i] <= odc_reg[i] ? pinSync_reg[i] : latch_reg[i];
            end else begin
               adcPinSample[i] <= pinSync_reg[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnPullupOn <= '0;
      end else begin
         cnPullupOn <= cnPu_reg[CN_COUNT-1:0];
      end
   end

   iopc_change_det #(
      .CN_COUNT (CN_COUNT)
   ) u_det (
      .core_clk    (core_clk),
      .reset       (reset),
      .cnPins      (cnPins),
      .cnEnable    (cnEn_reg[CN_COUNT-1:0]),
      .cnLevel     (),
      .changeEvent (changeEvent),
      .wakeReq     (wakeRaw)
   );

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnWake <= 1'b0;
      end else begin
         cnWake <= wakeRaw;
      end
   end

   // External interrupt 2 select; codes above the last pin read as ground
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         int2_reg     <= 1'b0;
         int2Prev_reg <= 1'b0;
      end else begin
         if (int2Sel_reg <= INT2SEL_MAX) begin
            int2_reg <= rpSync_reg[int2Sel_reg];
         end else begin
            int2_reg <= 1'b0;
         end
         // Previous level feeds the rising-edge status bit
         int2Prev_reg <= int2_reg;
      end
   end
   assign extInt2  = int2_reg;
   assign int2Rise = int2_reg && !int2Prev_reg;

   // Sticky status, write-one-to-clear; a new event wins over the clear
   always_comb begin
      irqStat_next = irqStat_reg;
      if (wr && hit(regAddr, OFF_IRQSTAT)) begin
         irqStat_next = irqStat_reg & ~regWdata[IRQ_W-1:0];
      end
      if (changeEvent) irqStat_next[IRQ_CN] = 1'b1;
      if (int2Rise)    irqStat_next[IRQ_INT2] = 1'b1;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irqStat_reg <= '0;
         irq         <= 1'b0;
      end else begin
         irqStat_reg <= irqStat_next;
         // Looks ahead at the next status so the line follows with no extra cycle
         irq         <= |(irqStat_next & irqMask_reg);
      end
   end

   // Read port: data in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         regRdata <= '0;
      end else if (regRead) begin
         unique case (regAddr)
            OFF_DIR:     regRdata <= dir_reg;
            OFF_PORT:    regRdata <= portView;
            OFF_LATCH:   regRdata <= latch_reg;
            OFF_ODC:     regRdata <= odc_reg;
            OFF_ANCFG:   regRdata <= ancfg_reg;
            OFF_CNEN_LO: regRdata <= cnEn_reg[15:0];
            OFF_CNEN_HI: regRdata <= cnEn_reg[31:16];
            OFF_CNPU_LO: regRdata <= cnPu_reg[15:0];
            OFF_CNPU_HI: regRdata <= cnPu_reg[31:16];
            OFF_INT2SEL: regRdata <= {11'h0, int2Sel_reg};
            OFF_IRQSTAT: regRdata <= {14'h0, irqStat_reg};
            OFF_IRQMASK: regRdata <= {14'h0, irqMask_reg};
            default:     regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end

   // Checks; bits 0 and 15 stand for every pin, since the logic is one per-bit loop
   od_high_a: assert property (@(posedge core_clk) disable iff (reset)
      ($past(odc_reg[0]) && !$past(reset)) |-> !(pinOe[0] && pinOut[0]))
      else $error("open-drain pin driven high");
   od_release_a: assert property (@(posedge core_clk) disable iff (reset)
      (odc_reg[0] && latch_reg[0]) |=> !pinOe[0])
      else $error("released open-drain pin still driven");
   pp_drive_a: assert property (@(posedge core_clk) disable iff (reset)
      !odc_reg[0]
         |=> (pinOe[0] == !$past(dir_reg[0]) && pinOut[0] == $past(latch_reg[0])))
      else $error("push-pull pin not driven from latch");
   analog_read_a: assert property (@(posedge core_clk) disable iff (reset)
      (regRead && regAddr == OFF_PORT) |=> ((regRdata & ~$past(ancfg_reg)) == 16'h0000))
      else $error("analog pin read as nonzero");
   digital_read_a: assert property (@(posedge core_clk) disable iff (reset)
      (regRead && regAddr == OFF_PORT && ancfg_reg[15])
         |=> (regRdata[15] == $past(pinSync_reg[15])))
      else $error("digital pin not readable");
   change_sets_a: assert property (@(posedge core_clk) disable iff (reset)
      changeEvent |=> irqStat_reg[IRQ_CN])
      else $error("change event lost");
   status_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr && regAddr == OFF_IRQSTAT && regWdata[IRQ_CN] && !changeEvent)
         |=> !irqStat_reg[IRQ_CN])
      else $error("change status not cleared by a written one");
   irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
      ##1 (irq == |($past(irqStat_next) & $past(irqMask_reg))))
      else $error("interrupt output mismatch");
   int2_gnd_a: assert property (@(posedge core_clk) disable iff (reset)
      (int2Sel_reg > INT2SEL_MAX) [*2] |-> !extInt2)
      else $error("grounded interrupt 2 input not low");
   int2_route_a: assert property (@(posedge core_clk) disable iff (reset)
      (int2Sel_reg <= INT2SEL_MAX)
         |=> (extInt2 == $past(rpSync_reg[int2Sel_reg])))
      else $error("interrupt 2 not routed from selected pin");
   int2_status_a: assert property (@(posedge core_clk) disable iff (reset)
      int2Rise |=> irqStat_reg[IRQ_INT2])
      else $error("interrupt 2 edge not recorded");
   pullup_map_a: assert property (@(posedge core_clk) disable iff (reset)
      ##1 (cnPullupOn == $past(cnPu_reg[CN_COUNT-1:0])))
      else $error("pull-up enables not applied");
   hi_pullup_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr && regAddr == OFF_CNPU_HI) |=> !cnPu_reg[31])
      else $error("unimplemented pull-up bit set");
   hi_enable_a: assert property (@(posedge core_clk) disable iff (reset)
      (wr && regAddr == OFF_CNEN_HI) |=> !cnEn_reg[31])
      else $error("unimplemented change enable bit set");
   adc_ground_a: assert property (@(posedge core_clk) disable iff (reset)
      ##1 (adcMuxGround == $past(ancfg_reg)))
      else $error("converter ground select wrong");
   adc_digital_a: assert property (@(posedge core_clk) disable iff (reset)
      ancfg_reg[15] |=> !adcPinSample[15])
      else $error("digital pin leaks a level to the converter");
   adc_analog_a: assert property (@(posedge core_clk) disable iff (reset)
      (!ancfg_reg[15] && dir_reg[15])
         |=> (adcPinSample[15] == $past(pinSync_reg[15])))
      else $error("analog input level not sampled");
   adc_drive_a: assert property (@(posedge core_clk) disable iff (reset)
      (!ancfg_reg[0] && !dir_reg[0] && !odc_reg[0])
         |=> adcPinSample[0] == $past(latch_reg[0]))
      else $error("driven level not presented to converter");
   wake_reg_a: assert property (@(posedge core_clk) disable iff (reset)
      wakeRaw |=> cnWake)
      else $error("wake request not passed on");

   // Cover the main scenarios
   cov_change_c: cover property (@(posedge core_clk) changeEvent ##1 irq);
   cov_int2_c:   cover property (@(posedge core_clk) int2Rise);
   cov_read_c:   cover property (@(posedge core_clk) regRead && regAddr == OFF_PORT);
   cov_wake_c:   cover property (@(posedge core_clk) cnWake ##1 !cnWake);
   cov_od_c:     cover property (@(posedge core_clk) odc_reg[0] && !pinOe[0] && pinSync_reg[0]);
endmodule

`default_nettype wire

//--- core/iopc_pkg.sv
// Package: register map, field layout and reset values of the I/O port block
//
// Functional notes
// - A set open-drain bit turns that pin's push-pull driver into open-drain.
// - An analog pin driven as output presents its latch level to the converter, or its pin level when open-drain.
// - Analog pin configuration resets to zero, so shared pins start analog.
// - Pin-value reads return zero for every pin configured analog.
// - Any enabled change input that changes state raises the change interrupt.
// - Change detection and the cnWake output both run on the instruction clock; neither works in Sleep while it is stopped.
// - Up to 31 change inputs; the implemented count is a parameter.
// - Two enable registers hold one change-interrupt enable bit per change pin.
// - Each change pin has a weak pull-up enabled by its bit in two registers.
// - Five-bit select routes remappable pin 0..25 to interrupt 2; 11111 grounds it.
// - Config bit set: digital, pin read on, converter grounded; clear: analog sampling.
// - Change enable and pull-up registers all reset to zero.
`default_nettype none

package iopc_pkg;
   localparam int PORT_W    = 16;
   localparam int CN_MAX    = 32;
   localparam int RP_COUNT  = 26;
   localparam int ADDR_W    = 8;
   // Byte offsets in the block's own register window
   localparam logic [7:0] OFF_DIR      = 8'h00;
   localparam logic [7:0] OFF_PORT     = 8'h02;
   localparam logic [7:0] OFF_LATCH    = 8'h04;
   localparam logic [7:0] OFF_ODC      = 8'h06;
   localparam logic [7:0] OFF_ANCFG    = 8'h08;
   localparam logic [7:0] OFF_CNEN_LO  = 8'h60;
   localparam logic [7:0] OFF_CNEN_HI  = 8'h62;
   localparam logic [7:0] OFF_CNPU_LO  = 8'h68;
   localparam logic [7:0] OFF_CNPU_HI  = 8'h6A;
   localparam logic [7:0] OFF_INT2SEL  = 8'h70;
   localparam logic [7:0] OFF_IRQSTAT  = 8'h72;
   localparam logic [7:0] OFF_IRQMASK  = 8'h74;
   localparam logic [15:0] DIR_RST     = 16'hFFFF;
   localparam logic [15:0] ZERO_RST    = 16'h0000;
   localparam logic [4:0]  INT2SEL_RST = 5'h1F;
   localparam logic [4:0]  INT2SEL_GND = 5'h1F;
   localparam logic [4:0]  INT2SEL_MAX = 5'h19;
   // Status / mask bit positions
   localparam int IRQ_CN   = 0;
   localparam int IRQ_INT2 = 1;
   localparam int IRQ_W    = 2;
endpackage

`default_nettype wire

//--- core/iopc_change_det.sv
// Change detector: synchronises change inputs and flags enabled mismatches
`default_nettype none

module iopc_change_det #(
   parameter int CN_COUNT = 21
) (
   input  wire logic                core_clk,
   input  wire logic                reset,
   input  wire logic [CN_COUNT-1:0] cnPins,
   input  wire logic [CN_COUNT-1:0] cnEnable,
   output logic     [CN_COUNT-1:0] cnLevel,
   output logic                    changeEvent,
   output logic                    wakeReq
);
   logic [CN_COUNT-1:0] syncA_reg;
   logic [CN_COUNT-1:0] syncB_reg;
   logic [CN_COUNT-1:0] prev_reg;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else begin
         syncA_reg <= cnPins;
         syncB_reg <= syncA_reg;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= syncB_reg;
      end
   end

   assign cnLevel     = syncB_reg;
   assign changeEvent = |((syncB_reg ^ prev_reg) & cnEnable);
   // Unclocked compare of raw pins against the last sample; the port registers
   // it into cnWake on core_clk, so a change cannot wake the core while core_clk is stopped
   assign wakeReq     = |((cnPins ^ prev_reg) & cnEnable);

   change_flag_a: assert property (@(posedge core_clk) disable iff (reset)
      (|((cnLevel ^ $past(cnLevel)) & cnEnable)) |-> changeEvent)
      else $error("enabled mismatch did not raise change event");
   no_enable_a: assert property (@(posedge core_clk) disable iff (reset)
      (cnEnable == '0) |-> !changeEvent)
      else $error("change event with all enables clear");
endmodule

`default_nettype wire

//--- testbench/iopc_pin_model.sv
// Board model: pull-ups on port pins, push-buttons to ground on change inputs
`default_nettype none

module iopc_pin_model #(
   parameter int CN_N = 31
) (
   input  wire logic            core_clk,
   input  wire logic [15:0]     pinOut,
   input  wire logic [15:0]     pinOe,
   input  wire logic [15:0]     extDrv,
   input  wire logic [15:0]     extEn,
   output logic      [15:0]     pinIn,
   input  wire logic [CN_N-1:0] cnPullupOn,
   input  wire logic [CN_N-1:0] cnPress,
   output logic      [CN_N-1:0] cnPins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CN_N-1:0] floatPat = '0;
   // An open input with nothing holding it must not look stable
   always @(posedge core_clk) begin
      floatPat <= ~floatPat;
   end
   // Board pull-up lifts a released open-drain pin
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extDrv[i] : 1'b1);
      end
   end
   // Weak pull-up holds an open button high
   assign cnPins = ~cnPress & (cnPullupOn | floatPat);
endmodule

`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the I/O port block
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import iopc_pkg::*;
   localparam int CN_N = 31;
   logic                core_clk = 1'b0;
   logic                reset;
   logic [ADDR_W-1:0]   regAddr;
   logic [15:0]         regWdata, regRdata, pinIn, pinOut, pinOe;
   logic [15:0]         adcPinSample, adcMuxGround, extDrv, extEn;
   logic                regWrite, regRead, extInt2, cnWake, irq;
   logic [CN_N-1:0]     cnPins, cnPullupOn, cnPress;
   logic [RP_COUNT-1:0] rpPins;
   int                  error_cnt = 0;
   int                  checks_done = 0;

   always #12.5 core_clk = ~core_clk;

   iopc_port #(.CN_COUNT(CN_N)) dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .adcPinSample(adcPinSample),
      .adcMuxGround(adcMuxGround), .cnPins(cnPins), .cnPullupOn(cnPullupOn),
      .rpPins(rpPins), .extInt2(extInt2), .cnWake(cnWake), .irq(irq));
   iopc_pin_model #(.CN_N(CN_N)) board (.core_clk(core_clk), .pinOut(pinOut),
      .pinOe(pinOe), .extDrv(extDrv), .extEn(extEn), .pinIn(pinIn),
      .cnPullupOn(cnPullupOn), .cnPress(cnPress), .cnPins(cnPins));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic regWr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 check({16'h0000, regRdata}, {16'h0000, exp}, what);
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Bounded wait on a level; a short pulse is still caught since every cycle is looked at
   task automatic waitHigh(input bit wake, input string what);
      int n;
      for (n = 0; n < 8 && (wake ? cnWake : irq) !== 1'b1; n++) waitCyc(1);
      check(wake ? cnWake : irq, 1'b1, what);
   endtask

   task automatic testReset();
      check(pinOe, 16'h0000, "oe at reset");
      check(cnPullupOn, 32'h0, "pull-ups at reset");
      check(adcMuxGround, 16'h0000, "mux ground at reset");
      rdChk(OFF_DIR, 16'hFFFF, "dir reset");
      rdChk(OFF_ANCFG, 16'h0000, "analog cfg reset");
      rdChk(OFF_CNEN_LO, 16'h0000, "cn en lo reset");
      rdChk(OFF_CNEN_HI, 16'h0000, "cn en hi reset");
      rdChk(OFF_CNPU_LO, 16'h0000, "cn pu lo reset");
      rdChk(OFF_CNPU_HI, 16'h0000, "cn pu hi reset");
      rdChk(OFF_INT2SEL, 16'h001F, "int2 select reset");
      rdChk(8'h40, 16'h0000, "unmapped read");
   endtask

   task automatic testDrive();
      regWr(OFF_LATCH, 16'hA5C3);
      regWr(OFF_DIR, 16'h0000);
      waitCyc(1);
      check(pinOe, 16'hFFFF, "push-pull oe");
      check(pinOut, 16'hA5C3, "push-pull out");
      regWr(OFF_ODC, 16'h00FF);
      waitCyc(4);
      check(pinOe, 16'hFF3C, "open-drain oe");
      check(pinOut, 16'hA500, "open-drain out");
      check(adcPinSample, 16'hA5C3, "converter sees output");
      rdChk(OFF_PORT, 16'h0000, "analog pins read low");
      regWr(OFF_ANCFG, 16'hFF00);
      waitCyc(1);
      check(adcMuxGround, 16'hFF00, "digital mux grounded");
      rdChk(OFF_PORT, 16'hA500, "digital pins read");
      regWr(OFF_ODC, 16'h0000);
      regWr(OFF_ANCFG, 16'h0000);
      // Analog inputs get their direction bits set first
      regWr(OFF_DIR, 16'hFFFF);
      @(posedge core_clk);
      extDrv <= 16'h3C5A;
      extEn <= 16'hFFFF;
      waitCyc(5);
      check(adcPinSample, 16'h3C5A, "analog input sampled");
      rdChk(OFF_PORT, 16'h0000, "analog input reads low");
      @(posedge core_clk) extEn <= 16'h0000;
   endtask

   task automatic testChange();
      regWr(OFF_IRQMASK, 16'h0001);
      // Pull-ups only on change pins that never act as port outputs
      regWr(OFF_CNPU_LO, 16'h0018);
      regWr(OFF_CNPU_HI, 16'h4000);
      regWr(OFF_CNEN_HI, 16'hFFFF);
      rdChk(OFF_CNEN_HI, 16'h7FFF, "cn en hi width");
      regWr(OFF_CNEN_HI, 16'h4000);
      regWr(OFF_CNEN_LO, 16'h0008);
      waitCyc(4);
      regWr(OFF_IRQSTAT, 16'h0003);
      waitCyc(2);
      check(cnPullupOn, 32'h4000_0018, "pull-ups on");
      check(irq, 1'b0, "status cleared");
      @(posedge core_clk) cnPress[4] <= 1'b1;
      waitCyc(6);
      check(irq, 1'b0, "disabled pin ignored");
      @(posedge core_clk) cnPress[3] <= 1'b1;
      waitHigh(1'b1, "wake on change");
      waitHigh(1'b0, "change irq");
      rdChk(OFF_IRQSTAT, 16'h0001, "cn status");
      regWr(OFF_IRQSTAT, 16'h0001);
      regWr(OFF_IRQMASK, 16'h0000);
      @(posedge core_clk) cnPress[3] <= 1'b0;
      waitCyc(6);
      check(irq, 1'b0, "masked change");
      rdChk(OFF_IRQSTAT, 16'h0001, "masked status set");
      regWr(OFF_IRQSTAT, 16'h0001);
      regWr(OFF_IRQMASK, 16'h0001);
      @(posedge core_clk) cnPress[30] <= 1'b1;
      waitHigh(1'b0, "high half change irq");
      regWr(OFF_IRQSTAT, 16'h0001);
   endtask

   task automatic testInt2();
      regWr(OFF_IRQMASK, 16'h0002);
      for (int c = 0; c < 26; c++) begin
         regWr(OFF_INT2SEL, 16'(c));
         rpPins <= 26'h1 << c;
         waitCyc(4);
         check(extInt2, 1'b1, "int2 routed high");
         @(posedge core_clk) rpPins <= ~(26'h1 << c);
         waitCyc(4);
         check(extInt2, 1'b0, "int2 routed low");
      end
      rdChk(OFF_IRQSTAT, 16'h0002, "int2 status");
      check(irq, 1'b1, "int2 irq");
      regWr(OFF_INT2SEL, 16'hFFFF);
      rpPins <= '1;
      waitCyc(4);
      check(extInt2, 1'b0, "int2 grounded");
      rdChk(OFF_INT2SEL, 16'h001F, "int2 select width");
   endtask

   task automatic results();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      regAddr = '0;
      regWdata = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
      extDrv = '0;
      extEn = '0;
      cnPress = '0;
      rpPins = '0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      waitCyc(1);
      testReset();
      testDrive();
      testChange();
      testInt2();
      results();
   end

   // Whole run needs about 430 cycles
   initial begin
      #(25 * 5000);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      results();
   end
endmodule

`default_nettype wire
